// ---- include/rapt_pkg.sv ----
package rapt_pkg;

    // Register map
    localparam logic [5:0] RAPT_CFG_ADDR        = 6'h18;
    localparam int         RAPT_AUTOCAL_LSB     = 4;
    localparam int         RAPT_TIMEOUT_LSB     = 2;
    localparam logic [1:0] RAPT_AUTOCAL_RESET   = 2'h0;
    localparam logic [1:0] RAPT_TIMEOUT_RESET   = 2'h1;

    // Calibration trigger settings
    localparam logic [1:0] RAPT_AC_NEVER        = 2'h0;
    localparam logic [1:0] RAPT_AC_FROM_IDLE    = 2'h1;
    localparam logic [1:0] RAPT_AC_TO_IDLE      = 2'h2;
    localparam logic [1:0] RAPT_AC_FOURTH       = 2'h3;
    localparam logic [1:0] RAPT_FOURTH_LAST     = 2'h3;

    // Ripple counter and expiry counts
    localparam int         RAPT_RIPPLE_WIDTH    = 6;
    localparam logic [5:0] RAPT_RIPPLE_LAST     = 6'h3f;
    localparam logic [8:0] RAPT_EXPIRE_SEL0     = 9'h001;
    localparam logic [8:0] RAPT_EXPIRE_SEL1     = 9'h010;
    localparam logic [8:0] RAPT_EXPIRE_SEL2     = 9'h040;
    localparam logic [8:0] RAPT_EXPIRE_SEL3     = 9'h100;

    // Radio control state as reported by the main state machine
    typedef enum logic [1:0] {
        RAPT_RADIO_IDLE = 2'h0,
        RAPT_RADIO_RX   = 2'h1,
        RAPT_RADIO_TX   = 2'h2,
        RAPT_RADIO_FSTX = 2'h3
    } rapt_radio_t;

    // Power-up sequencer, Gray along wait -> count -> ready
    typedef enum logic [1:0] {
        RAPT_PU_WAIT  = 2'b00,
        RAPT_PU_COUNT = 2'b01,
        RAPT_PU_READY = 2'b11
    } rapt_pu_t;

    // Register access request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [5:0] addr;
        logic [7:0] wdata;
    } rapt_req_t;

endpackage

// ---- verilog/rapt_ripple.sv ----
`timescale 1ns/1ps
`default_nettype none
module rapt_ripple
    import rapt_pkg::*;
(
    // Clock and reset
    input  wire logic clock,
    input  wire logic sys_rst,
    // Control
    input  wire logic run,
    output logic      expire
);

    logic [RAPT_RIPPLE_WIDTH-1:0] cnt_q;
    wire  logic                   at_last = (cnt_q == RAPT_RIPPLE_LAST);

    // Free counter, cleared whenever stopped so each start is a full period
    always_ff @(posedge clock) begin
        if (sys_rst || !run) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    assign expire = run && at_last;

endmodule
`default_nettype wire

// ---- verilog/rapt_top.sv ----
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Setting 00: no automatic calibration, only the calibrate strobe starts one.
// - Setting 01: calibrate when leaving idle for receive, transmit or synth-on.
// - Setting 10: calibrate when returning from receive or transmit to idle.
// - Setting 11: calibrate on every fourth return to idle.
// - Trigger selection in bits 5:4, read/write, resets to 00.
// - Chip-ready stays high until ripple counter expired selected times, then low.
module rapt_top
    import rapt_pkg::*;
#(
    parameter logic [8:0] PO_LONG_EXPIRES = RAPT_EXPIRE_SEL3
)
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        sys_rst,
    // Register access
    input  wire rapt_req_t   reg_req,
    output logic [7:0]       reg_rdata_q,
    // Radio control state machine
    input  wire rapt_radio_t radio_state,
    input  wire logic        calibrate_strobe,
    output logic             cal_start_q,
    // Crystal oscillator and readiness
    input  wire logic        xosc_run,
    output logic             chip_ready_low_q
);

    // Expiry count for a timeout setting
    function automatic logic [8:0] expire_target(input logic [1:0] sel);
        logic [8:0] t;
        t = RAPT_EXPIRE_SEL0;
        unique case (sel)
            2'h0: t = RAPT_EXPIRE_SEL0;
            2'h1: t = RAPT_EXPIRE_SEL1;
            2'h2: t = RAPT_EXPIRE_SEL2;
            2'h3: t = PO_LONG_EXPIRES;
        endcase
        return t;
    endfunction

    logic [1:0]  autocal_q;
    logic [1:0]  timeout_q;
    logic [1:0]  fourth_q;
    logic [1:0]  fourth_d;
    logic [8:0]  exp_cnt_q;
    rapt_radio_t prev_state_q;
    rapt_pu_t    pu_q;
    rapt_pu_t    pu_d;
    logic        expire;

    // Register decode
    wire logic hit      = (reg_req.addr == RAPT_CFG_ADDR);
    wire logic cfg_wr   = reg_req.wr && hit;
    wire logic [7:0] cfg_view = {2'b00, autocal_q, timeout_q, 2'b00};
    wire logic [7:0] rd_next  = (reg_req.rd && hit) ? cfg_view : 8'h00;

    // Only the two live fields are stored; other bits are dropped
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            autocal_q   <= RAPT_AUTOCAL_RESET;
            timeout_q   <= RAPT_TIMEOUT_RESET;
            reg_rdata_q <= 8'h00;
        end else begin
            if (cfg_wr) begin
                autocal_q <= reg_req.wdata[RAPT_AUTOCAL_LSB +: 2];
                timeout_q <= reg_req.wdata[RAPT_TIMEOUT_LSB +: 2];
            end
            reg_rdata_q <= rd_next;
        end
    end

    // Transition detection against last cycle's radio state
    wire logic was_active = (prev_state_q == RAPT_RADIO_RX) ||
                            (prev_state_q == RAPT_RADIO_TX);
    wire logic now_busy   = (radio_state != RAPT_RADIO_IDLE);
    wire logic leave_idle = (prev_state_q == RAPT_RADIO_IDLE) && now_busy;
    wire logic back_idle  = was_active && (radio_state == RAPT_RADIO_IDLE);

    // Trigger selection
    wire logic fourth_hit = back_idle && (fourth_q == RAPT_FOURTH_LAST);
    wire logic auto_cal   =
        ((autocal_q == RAPT_AC_FROM_IDLE) && leave_idle) ||
        ((autocal_q == RAPT_AC_TO_IDLE)   && back_idle)  ||
        ((autocal_q == RAPT_AC_FOURTH)    && fourth_hit);
    wire logic cal_next   = calibrate_strobe || auto_cal;

    // Fourth-return counter only advances in setting 11
    always_comb begin
        fourth_d = fourth_q;
        if ((autocal_q == RAPT_AC_FOURTH) && back_idle) begin
            fourth_d = fourth_q + 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            prev_state_q <= RAPT_RADIO_IDLE;
            fourth_q     <= 2'h0;
            cal_start_q  <= 1'b0;
        end else begin
            prev_state_q <= radio_state;
            fourth_q     <= fourth_d;
            cal_start_q  <= cal_next;
        end
    end

    // Power-up ripple counter
    rapt_ripple u_ripple (
        .clock   (clock),
        .sys_rst (sys_rst),
        .run     (pu_q == RAPT_PU_COUNT),
        .expire  (expire)
    );

    wire logic [8:0] exp_next = exp_cnt_q + 9'h001;
    wire logic       done     = expire &&
                                (exp_next == expire_target(timeout_q));

    // Sequencer; a stopped crystal always drops back to waiting
    always_comb begin
        pu_d = pu_q;
        unique case (pu_q)
            RAPT_PU_WAIT:  if (xosc_run) pu_d = RAPT_PU_COUNT;
            RAPT_PU_COUNT: if (!xosc_run) pu_d = RAPT_PU_WAIT;
                           else if (done) pu_d = RAPT_PU_READY;
            RAPT_PU_READY: if (!xosc_run) pu_d = RAPT_PU_WAIT;
            default:       pu_d = RAPT_PU_WAIT;
        endcase
    end

    // Ready is a flop so it never glitches on the pin
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pu_q             <= RAPT_PU_WAIT;
            exp_cnt_q        <= 9'h000;
            chip_ready_low_q <= 1'b1;
        end else begin
            pu_q             <= pu_d;
            chip_ready_low_q <= (pu_d != RAPT_PU_READY);
            if (pu_q != RAPT_PU_COUNT) begin
                exp_cnt_q <= 9'h000;
            end else if (expire) begin
                exp_cnt_q <= exp_next;
            end
        end
    end

    // Checks
    sequence s_to_idle_last;
        (autocal_q == RAPT_AC_FOURTH) && back_idle &&
        (fourth_q == RAPT_FOURTH_LAST);
    endsequence

    sequence s_cal_and_wrap;
        cal_start_q && (fourth_q == 2'h0);
    endsequence

    never_auto_cal_a: assert property (@(posedge clock) disable iff (sys_rst)
        (autocal_q == RAPT_AC_NEVER && !calibrate_strobe) |=> !cal_start_q)
        else $error("automatic calibration in setting 00");

    from_idle_cal_a: assert property (@(posedge clock) disable iff (sys_rst)
        (autocal_q == RAPT_AC_FROM_IDLE && leave_idle) |=> cal_start_q)
        else $error("no calibration leaving idle");

    to_idle_cal_a: assert property (@(posedge clock) disable iff (sys_rst)
        (autocal_q == RAPT_AC_TO_IDLE && back_idle) |=> cal_start_q)
        else $error("no calibration returning to idle");

    fourth_cal_a: assert property (@(posedge clock) disable iff (sys_rst)
        s_to_idle_last |=> s_cal_and_wrap)
        else $error("fourth return did not calibrate and wrap");

    fourth_skip_a: assert property (@(posedge clock) disable iff (sys_rst)
        (autocal_q == RAPT_AC_FOURTH && back_idle &&
         fourth_q != RAPT_FOURTH_LAST && !calibrate_strobe) |=> !cal_start_q)
        else $error("calibration before fourth return");

    cfg_reset_a: assert property (@(posedge clock)
        sys_rst |=> (autocal_q == RAPT_AC_NEVER) &&
                    (timeout_q == RAPT_TIMEOUT_RESET) && (fourth_q == 2'h0))
        else $error("configuration reset value wrong");

    ready_cause_a: assert property (@(posedge clock) disable iff (sys_rst)
        $fell(chip_ready_low_q) |->
            $past(expire) && $past(exp_next) == $past(expire_target(timeout_q)))
        else $error("chip ready before expiry count");

    ready_drop_a: assert property (@(posedge clock) disable iff (sys_rst)
        !xosc_run |=> chip_ready_low_q)
        else $error("chip ready without crystal");

    reserved_zero_a: assert property (@(posedge clock) disable iff (sys_rst)
        (reg_rdata_q[7:6] == 2'b00) && (reg_rdata_q[1:0] == 2'b00))
        else $error("reserved bits read nonzero");

    write_read_a: assert property (@(posedge clock) disable iff (sys_rst)
        (cfg_wr && !reg_req.rd) ##1 (reg_req.rd && hit && !cfg_wr) |=>
            reg_rdata_q[5:2] == $past(reg_req.wdata[5:2], 2))
        else $error("field readback mismatch");

endmodule
`default_nettype wire

// ---- test/rapt_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module rapt_bench
    import rapt_pkg::*;
();
    // Short long-timeout count keeps the run brief
    localparam logic [8:0] PO_LONG = 9'h004;

    typedef struct {
        logic [1:0]  sel;
        rapt_radio_t st;
        int          exp;
    } rapt_row_t;

    logic        clock = 1'b0;
    logic        sys_rst = 1'b1;
    rapt_req_t   reg_req = '0;
    logic [7:0]  reg_rdata_q;
    rapt_radio_t radio_state = RAPT_RADIO_IDLE;
    logic        calibrate_strobe = 1'b0;
    logic        cal_start_q;
    logic        xosc_run = 1'b0;
    logic        chip_ready_low_q;
    int          err_count = 0;
    int          n_compared = 0;
    int          cycles = 0;
    int          n;
    int          po_n [4] = '{RAPT_EXPIRE_SEL0, RAPT_EXPIRE_SEL1,
                              RAPT_EXPIRE_SEL2, PO_LONG};
    // Selection, next radio state, calibrations expected
    rapt_row_t   rows [24] = '{
        '{2'h0, RAPT_RADIO_TX, 0}, '{2'h0, RAPT_RADIO_IDLE, 0},
        '{2'h1, RAPT_RADIO_RX, 1}, '{2'h1, RAPT_RADIO_IDLE, 0},
        '{2'h1, RAPT_RADIO_FSTX, 1}, '{2'h1, RAPT_RADIO_IDLE, 0},
        '{2'h1, RAPT_RADIO_TX, 1}, '{2'h1, RAPT_RADIO_IDLE, 0},
        '{2'h2, RAPT_RADIO_RX, 0}, '{2'h2, RAPT_RADIO_IDLE, 1},
        '{2'h2, RAPT_RADIO_TX, 0}, '{2'h2, RAPT_RADIO_IDLE, 1},
        '{2'h2, RAPT_RADIO_FSTX, 0}, '{2'h2, RAPT_RADIO_IDLE, 0},
        '{2'h3, RAPT_RADIO_TX, 0}, '{2'h3, RAPT_RADIO_IDLE, 0},
        '{2'h3, RAPT_RADIO_RX, 0}, '{2'h3, RAPT_RADIO_IDLE, 0},
        '{2'h3, RAPT_RADIO_TX, 0}, '{2'h3, RAPT_RADIO_IDLE, 0},
        '{2'h3, RAPT_RADIO_RX, 0}, '{2'h3, RAPT_RADIO_IDLE, 1},
        '{2'h3, RAPT_RADIO_TX, 0}, '{2'h3, RAPT_RADIO_IDLE, 0}};

    rapt_top #(.PO_LONG_EXPIRES(PO_LONG)) uut (
        .clock            (clock),
        .sys_rst          (sys_rst),
        .reg_req          (reg_req),
        .reg_rdata_q      (reg_rdata_q),
        .radio_state      (radio_state),
        .calibrate_strobe (calibrate_strobe),
        .cal_start_q      (cal_start_q),
        .xosc_run         (xosc_run),
        .chip_ready_low_q (chip_ready_low_q)
    );

    // Free-running clock
    always #5 clock = ~clock;

    // Hang guard, well above the expected run length
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        if (err_count == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic tick(input int k);
        repeat (k) @(negedge clock);
    endtask

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Counts and latencies, within a tolerance
    task automatic chk_num(input int got, input int exp, input int tol);
        n_compared++;
        if (got > exp + tol || got < exp - tol) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Strobes held one cycle, then released a cycle before the next use
    task automatic reg_wr(input logic [5:0] a, input logic [7:0] d);
        reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        tick(1);
        reg_req = '0;
        tick(1);
    endtask

    task automatic reg_rd(input logic [5:0] a, input logic [7:0] exp);
        reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        tick(1);
        reg_req = '0;
        chk_byte(reg_rdata_q, exp);
        tick(1);
    endtask

    // Unknown pulse level counts as a large miss
    task automatic move(input rapt_radio_t s, input logic stb, output int c);
        radio_state = s;
        calibrate_strobe = stb;
        c = 0;
        repeat (5) begin
            tick(1);
            calibrate_strobe = 1'b0;
            c += (cal_start_q === 1'b1) ? 1 : (cal_start_q === 1'b0) ? 0 : 99;
        end
    endtask

    // Main sequence
    initial begin
        tick(8);
        sys_rst = 1'b0;
        tick(1);
        chk_byte({7'h0, chip_ready_low_q}, 8'h01);
        reg_rd(RAPT_CFG_ADDR, 8'h04);
        foreach (rows[i]) begin
            reg_wr(RAPT_CFG_ADDR, {2'h0, rows[i].sel, 4'h4});
            move(rows[i].st, 1'b0, n);
            chk_num(n, rows[i].exp, 0);
        end
        reg_wr(RAPT_CFG_ADDR, 8'h04);
        move(RAPT_RADIO_IDLE, 1'b1, n);
        chk_num(n, 1, 0);
        // Back-to-back write then read, no idle cycle between them
        reg_req = '{wr: 1'b1, rd: 1'b0, addr: RAPT_CFG_ADDR, wdata: 8'h28};
        tick(1);
        reg_req = '{wr: 1'b0, rd: 1'b1, addr: RAPT_CFG_ADDR, wdata: 8'h00};
        tick(1);
        reg_req = '0;
        chk_byte(reg_rdata_q, 8'h28);
        tick(1);
        reg_wr(RAPT_CFG_ADDR, 8'hff);
        reg_rd(RAPT_CFG_ADDR, 8'h3c);
        reg_wr(6'h19, 8'h00);
        reg_rd(RAPT_CFG_ADDR, 8'h3c);
        reg_rd(6'h19, 8'h00);
        // Leave the fourth-return count part way, then reset mid-run
        repeat (2) begin
            move(RAPT_RADIO_TX, 1'b0, n);
            move(RAPT_RADIO_IDLE, 1'b0, n);
        end
        sys_rst = 1'b1;
        tick(2);
        sys_rst = 1'b0;
        tick(1);
        chk_byte({6'h0, cal_start_q, chip_ready_low_q}, 8'h01);
        reg_rd(RAPT_CFG_ADDR, 8'h04);
        reg_wr(RAPT_CFG_ADDR, 8'h34);
        for (int k = 1; k <= 4; k++) begin
            move(RAPT_RADIO_RX, 1'b0, n);
            move(RAPT_RADIO_IDLE, 1'b0, n);
            chk_num(n, (k == 4) ? 1 : 0, 0);
        end
        // Ready delay for each timeout selection; the crystal is taken
        // as low-ESR, so even the shortest setting is a fair choice
        for (int t = 0; t < 4; t++) begin
            reg_wr(RAPT_CFG_ADDR, {4'h0, t[1:0], 2'h0});
            xosc_run = 1'b1;
            n = 0;
            while (chip_ready_low_q !== 1'b0 && n < 20000) begin
                tick(1);
                n++;
            end
            chk_num(n, 64 * po_n[t] + 1, 0);
            xosc_run = 1'b0;
            tick(2);
            chk_byte({7'h0, chip_ready_low_q}, 8'h01);
        end
        end_of_test();
    end
endmodule
`default_nettype wire
